// ==== src/ucb_pkg.sv ====
// Constants, register map and carrier types of the current unbalance block
package ucb_pkg;

	// ********************************************************************
	// Register map (byte addresses)
	// ********************************************************************
	localparam int          UCB_ADDR_W    = 8;
	localparam logic [7:0]  UCB_OFS_CTRL   = 8'h00;
	localparam logic [7:0]  UCB_OFS_THRESH = 8'h04;
	localparam logic [7:0]  UCB_OFS_DELAY  = 8'h08;
	localparam logic [7:0]  UCB_OFS_RATED  = 8'h0C;
	localparam logic [7:0]  UCB_OFS_STATUS = 8'h10;
	localparam logic [7:0]  UCB_OFS_MASK   = 8'h14;
	localparam logic [7:0]  UCB_OFS_STATE  = 8'h18;
	localparam logic [7:0]  UCB_OFS_PEAK   = 8'h1C;

	// ********************************************************************
	// Fields and reset values
	// ********************************************************************
	localparam int          UCB_CTRL_OPER_BIT   = 0;
	localparam int          UCB_CTRL_STONLY_BIT = 1;
	localparam logic [1:0]  UCB_CTRL_RST   = 2'h0;
	localparam logic [6:0]  UCB_THR_MIN    = 7'h0A;
	localparam logic [6:0]  UCB_THR_MAX    = 7'h5A;
	localparam logic [6:0]  UCB_THR_RST    = 7'h32;
	localparam logic [15:0] UCB_DLY_MIN    = 16'h0064;
	localparam logic [15:0] UCB_DLY_MAX    = 16'hEA60;
	localparam logic [15:0] UCB_DLY_RST    = 16'h03E8;
	localparam logic [15:0] UCB_RATED_RST  = 16'h0400;
	localparam int          UCB_IRQ_START   = 0;
	localparam int          UCB_IRQ_TRIP    = 1;
	localparam int          UCB_IRQ_RELEASE = 2;
	localparam int          UCB_IRQ_W       = 3;
	localparam logic [2:0]  UCB_IRQ_RST    = 3'h0;
	localparam logic [1:0]  UCB_RESP_OKAY  = 2'h0;
	localparam logic [1:0]  UCB_RESP_SLVERR = 2'h2;

	// ********************************************************************
	// Ratios: range 10 % .. 150 % of rated, reset ratio 0.95 = 19 / 20
	// ********************************************************************
	localparam logic [31:0] UCB_PCT        = 32'h0000_0064;
	localparam logic [31:0] UCB_RANGE_LO   = 32'h0000_000A;
	localparam logic [31:0] UCB_RANGE_HI   = 32'h0000_0096;
	localparam logic [31:0] UCB_REL_NUM    = 32'h0000_0013;
	localparam logic [31:0] UCB_REL_DEN    = 32'h0000_0014;

	// ********************************************************************
	// Timing
	// ********************************************************************
	localparam int          UCB_CLK_PERIOD_NS = 100;
	localparam int          UCB_MS_NS         = 1000000;
	localparam int          UCB_MS_CYCLES     = UCB_MS_NS / UCB_CLK_PERIOD_NS;

	// ********************************************************************
	// Types
	// ********************************************************************
	typedef struct packed {
		logic [15:0] ia;
		logic [15:0] ib;
		logic [15:0] ic;
	} ucb_phase_t;

	typedef struct packed {
		logic [15:0] imax;
		logic [15:0] imin;
		logic        range_ok;
		logic        over_thr;
		logic        under_rel;
	} ucb_result_t;

	typedef enum logic [1:0] {
		UCB_ST_IDLE    = 2'b00,
		UCB_ST_STARTED = 2'b01,
		UCB_ST_TRIPPED = 2'b10
	} ucb_state_t;

endpackage

// ==== src/ucb_eval.sv ====
// Evaluator: max/min of phase currents, range and spread comparisons
`timescale 1ns/10ps
module ucb_eval
	import ucb_pkg::*;
(
	input  wire logic        mclk_in,
	input  wire logic        rst_n_in,
	input  wire logic        sample_valid_in,
	input  wire ucb_phase_t  phase_in,
	input  wire logic [6:0]  thr_in,
	input  wire logic [15:0] rated_in,
	output ucb_result_t      res_out,
	output logic             res_valid_out
);

	wire logic [15:0] max_ab;
	wire logic [15:0] min_ab;
	wire logic [15:0] imax;
	wire logic [15:0] imin;
	wire logic [31:0] max32;
	wire logic [31:0] diff_pct;
	wire logic [31:0] thr_max;
	wire logic [31:0] rated32;
	wire ucb_result_t res_next;

	assign max_ab   = (phase_in.ia > phase_in.ib) ? phase_in.ia : phase_in.ib;
	assign min_ab   = (phase_in.ia < phase_in.ib) ? phase_in.ia : phase_in.ib;
	assign imax     = (max_ab > phase_in.ic) ? max_ab : phase_in.ic;
	assign imin     = (min_ab < phase_in.ic) ? min_ab : phase_in.ic;
	assign max32    = {16'h0000, imax};
	assign rated32  = {16'h0000, rated_in};
	// Spread in percent of max, compared without a divider
	assign diff_pct = {16'h0000, imax - imin} * UCB_PCT;
	assign thr_max  = {25'h000_0000, thr_in} * max32;

	assign res_next.imax      = imax;
	assign res_next.imin      = imin;
	assign res_next.range_ok  = (max32 * UCB_PCT > rated32 * UCB_RANGE_LO) &&
	                            (max32 * UCB_PCT < rated32 * UCB_RANGE_HI);
	assign res_next.over_thr  = diff_pct > thr_max;
	assign res_next.under_rel = diff_pct * UCB_REL_DEN <
	                            thr_max * UCB_REL_NUM;

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			res_out       <= '0;
			res_valid_out <= 1'b0;
		end else begin
			res_valid_out <= sample_valid_in;
			if (sample_valid_in) begin
				res_out <= res_next;
			end
		end
	end

	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);

	a_max_above_min: assert property (
		res_valid_out |-> res_out.imax >= res_out.imin)
		else $error("max below min");
	a_over_implies_not_rel: assert property (
		res_valid_out && res_out.over_thr |-> !res_out.under_rel)
		else $error("over threshold and under release at once");

endmodule // ucb_eval

// ==== src/ucb_top.sv ====
// Current unbalance detector with AXI4-Lite register slave
// How it works
// - Find largest and smallest phase RMS current
// - Spread is difference as percent of largest
// - Start allowed only for 10..150 % rated
// - In range and spread over threshold: start
// - Start held for delay: trip if enabled
// - Start-only flag set suppresses trip; default zero
// - Disabled by control or block input: start and trip outputs off
// - Operation select Off/On, Off after reset
// - Threshold 10..90 percent, default 50
// - Delay 100..60000 ms, default 1000
// - Release below 0.95 of threshold
`timescale 1ns/10ps
module ucb_top
	import ucb_pkg::*;
#(
	parameter int unsigned MS_CYCLES = UCB_MS_CYCLES
)(
	input  wire logic                  mclk_in,
	input  wire logic                  rst_n_in,
	input  wire logic [UCB_ADDR_W-1:0] s_axi_awaddr_in,
	input  wire logic                  s_axi_awvalid_in,
	output logic                       s_axi_awready_out,
	input  wire logic [31:0]           s_axi_wdata_in,
	input  wire logic [3:0]            s_axi_wstrb_in,
	input  wire logic                  s_axi_wvalid_in,
	output logic                       s_axi_wready_out,
	output logic [1:0]                 s_axi_bresp_out,
	output logic                       s_axi_bvalid_out,
	input  wire logic                  s_axi_bready_in,
	input  wire logic [UCB_ADDR_W-1:0] s_axi_araddr_in,
	input  wire logic                  s_axi_arvalid_in,
	output logic                       s_axi_arready_out,
	output logic [31:0]                s_axi_rdata_out,
	output logic [1:0]                 s_axi_rresp_out,
	output logic                       s_axi_rvalid_out,
	input  wire logic                  s_axi_rready_in,
	input  wire ucb_phase_t            phase_in,
	input  wire logic                  sample_valid_in,
	input  wire logic                  block_in,
	output logic                       start_out,
	output logic                       trip_out,
	output logic                       irq_out
);

	localparam logic [15:0] PRE_LAST = 16'(MS_CYCLES - 1);

	// ********************************************************************
	// Declarations
	// ********************************************************************
	logic                  aw_hold_reg;
	logic                  w_hold_reg;
	logic [UCB_ADDR_W-1:0] awaddr_reg;
	logic [31:0]           wdata_reg;
	logic [3:0]            wstrb_reg;
	logic                  bvalid_reg;
	logic [1:0]            ctrl_reg;
	logic [6:0]            thr_reg;
	logic [15:0]           dly_reg;
	logic [15:0]           rated_reg;
	logic [UCB_IRQ_W-1:0]  status_reg;
	logic [UCB_IRQ_W-1:0]  mask_reg;
	ucb_state_t            state_reg;
	ucb_state_t            state_next;
	logic [15:0]           pre_cnt_reg;
	logic [15:0]           ms_cnt_reg;
	ucb_result_t           res;
	logic                  res_valid;

	wire logic                 aw_take;
	wire logic                 w_take;
	wire logic                 do_write;
	wire logic                 ar_take;
	wire logic                 aw_hold_next;
	wire logic                 w_hold_next;
	wire logic                 rvalid_next;
	wire logic [31:0]          wmask;
	wire logic [31:0]          wr_ctrl_val;
	wire logic [31:0]          wr_thr_val;
	wire logic [31:0]          wr_dly_val;
	wire logic [31:0]          wr_rated_val;
	wire logic [31:0]          wr_w1c_val;
	wire logic [31:0]          wr_mask_val;
	wire logic                 wr_ctrl;
	wire logic                 wr_thr;
	wire logic                 wr_dly;
	wire logic                 wr_rated;
	wire logic                 wr_status;
	wire logic                 wr_mask;
	wire logic                 wr_hit;
	wire logic                 rd_hit;
	wire logic [31:0]          rd_word;
	wire logic                 enabled;
	wire logic                 start_only;
	wire logic                 ms_tick;
	wire logic                 dly_done;
	wire logic                 release_cond;
	wire logic [UCB_IRQ_W-1:0] events;
	wire logic [UCB_IRQ_W-1:0] status_next;
	wire logic [UCB_IRQ_W-1:0] mask_next;

	// ********************************************************************
	// Evaluator
	// ********************************************************************
	ucb_eval u_eval (
		.mclk_in         (mclk_in),
		.rst_n_in        (rst_n_in),
		.sample_valid_in (sample_valid_in),
		.phase_in        (phase_in),
		.thr_in          (thr_reg),
		.rated_in        (rated_reg),
		.res_out         (res),
		.res_valid_out   (res_valid)
	);

	// ********************************************************************
	// AXI4-Lite handshakes
	// ********************************************************************
	assign aw_take      = s_axi_awvalid_in & s_axi_awready_out;
	assign w_take       = s_axi_wvalid_in & s_axi_wready_out;
	assign do_write     = aw_hold_reg & w_hold_reg & ~bvalid_reg;
	assign aw_hold_next = (aw_hold_reg & ~do_write) | aw_take;
	assign w_hold_next  = (w_hold_reg & ~do_write) | w_take;
	assign ar_take      = s_axi_arvalid_in & s_axi_arready_out;
	assign rvalid_next  = (s_axi_rvalid_out & ~s_axi_rready_in) | ar_take;

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			aw_hold_reg       <= 1'b0;
			w_hold_reg        <= 1'b0;
			s_axi_awready_out <= 1'b1;
			s_axi_wready_out  <= 1'b1;
			awaddr_reg        <= '0;
			wdata_reg         <= '0;
			wstrb_reg         <= '0;
		end else begin
			aw_hold_reg       <= aw_hold_next;
			w_hold_reg        <= w_hold_next;
			s_axi_awready_out <= ~aw_hold_next;
			s_axi_wready_out  <= ~w_hold_next;
			if (aw_take) begin
				awaddr_reg <= s_axi_awaddr_in;
			end
			if (w_take) begin
				wdata_reg <= s_axi_wdata_in;
				wstrb_reg <= s_axi_wstrb_in;
			end
		end
	end

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			bvalid_reg      <= 1'b0;
			s_axi_bresp_out <= UCB_RESP_OKAY;
		end else if (do_write) begin
			bvalid_reg      <= 1'b1;
			s_axi_bresp_out <= wr_hit ? UCB_RESP_OKAY : UCB_RESP_SLVERR;
		end else if (s_axi_bready_in) begin
			bvalid_reg <= 1'b0;
		end
	end
	assign s_axi_bvalid_out = bvalid_reg;

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s_axi_rvalid_out  <= 1'b0;
			s_axi_arready_out <= 1'b1;
			s_axi_rdata_out   <= '0;
			s_axi_rresp_out   <= UCB_RESP_OKAY;
		end else begin
			s_axi_rvalid_out  <= rvalid_next;
			s_axi_arready_out <= ~rvalid_next;
			if (ar_take) begin
				s_axi_rdata_out <= rd_word;
				s_axi_rresp_out <= rd_hit ? UCB_RESP_OKAY : UCB_RESP_SLVERR;
			end
		end
	end

	// ********************************************************************
	// Write decode with byte lanes
	// ********************************************************************
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_lane
			assign wmask[gi*8 +: 8] = {8{wstrb_reg[gi]}};
		end
	endgenerate

	function automatic logic [31:0] merge(input logic [31:0] old,
	                                      input logic [31:0] mask,
	                                      input logic [31:0] data);
		merge = (old & ~mask) | (data & mask);
	endfunction

	assign wr_ctrl   = do_write & (awaddr_reg == UCB_OFS_CTRL);
	assign wr_thr    = do_write & (awaddr_reg == UCB_OFS_THRESH);
	assign wr_dly    = do_write & (awaddr_reg == UCB_OFS_DELAY);
	assign wr_rated  = do_write & (awaddr_reg == UCB_OFS_RATED);
	assign wr_status = do_write & (awaddr_reg == UCB_OFS_STATUS);
	assign wr_mask   = do_write & (awaddr_reg == UCB_OFS_MASK);
	assign wr_hit    = wr_ctrl | wr_thr | wr_dly | wr_rated |
	                   wr_status | wr_mask |
	                   (awaddr_reg == UCB_OFS_STATE) |
	                   (awaddr_reg == UCB_OFS_PEAK);

	assign wr_ctrl_val  = merge({30'h0000_0000, ctrl_reg}, wmask, wdata_reg);
	assign wr_thr_val   = merge({25'h000_0000, thr_reg}, wmask, wdata_reg);
	assign wr_dly_val   = merge({16'h0000, dly_reg}, wmask, wdata_reg);
	assign wr_rated_val = merge({16'h0000, rated_reg}, wmask, wdata_reg);
	assign wr_w1c_val   = wdata_reg & wmask;
	assign wr_mask_val  = merge({29'h0000_0000, mask_reg}, wmask, wdata_reg);

	// ********************************************************************
	// Settings registers, threshold and delay clamped to their ranges
	// ********************************************************************
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ctrl_reg  <= UCB_CTRL_RST;
			thr_reg   <= UCB_THR_RST;
			dly_reg   <= UCB_DLY_RST;
			rated_reg <= UCB_RATED_RST;
		end else begin
			if (wr_ctrl) begin
				ctrl_reg <= wr_ctrl_val[1:0];
			end
			if (wr_thr) begin
				thr_reg <= (wr_thr_val < {25'h000_0000, UCB_THR_MIN}) ?
				           UCB_THR_MIN :
				           (wr_thr_val > {25'h000_0000, UCB_THR_MAX}) ?
				           UCB_THR_MAX : wr_thr_val[6:0];
			end
			if (wr_dly) begin
				dly_reg <= (wr_dly_val < {16'h0000, UCB_DLY_MIN}) ?
				           UCB_DLY_MIN :
				           (wr_dly_val > {16'h0000, UCB_DLY_MAX}) ?
				           UCB_DLY_MAX : wr_dly_val[15:0];
			end
			if (wr_rated) begin
				rated_reg <= wr_rated_val[15:0];
			end
		end
	end

	// ********************************************************************
	// Read mux
	// ********************************************************************
	assign rd_hit  = (s_axi_araddr_in == UCB_OFS_CTRL)   |
	                 (s_axi_araddr_in == UCB_OFS_THRESH) |
	                 (s_axi_araddr_in == UCB_OFS_DELAY)  |
	                 (s_axi_araddr_in == UCB_OFS_RATED)  |
	                 (s_axi_araddr_in == UCB_OFS_STATUS) |
	                 (s_axi_araddr_in == UCB_OFS_MASK)   |
	                 (s_axi_araddr_in == UCB_OFS_STATE)  |
	                 (s_axi_araddr_in == UCB_OFS_PEAK);
	assign rd_word =
		(s_axi_araddr_in == UCB_OFS_CTRL)   ? {30'h0000_0000, ctrl_reg} :
		(s_axi_araddr_in == UCB_OFS_THRESH) ? {25'h000_0000, thr_reg} :
		(s_axi_araddr_in == UCB_OFS_DELAY)  ? {16'h0000, dly_reg} :
		(s_axi_araddr_in == UCB_OFS_RATED)  ? {16'h0000, rated_reg} :
		(s_axi_araddr_in == UCB_OFS_STATUS) ? {29'h0000_0000, status_reg} :
		(s_axi_araddr_in == UCB_OFS_MASK)   ? {29'h0000_0000, mask_reg} :
		(s_axi_araddr_in == UCB_OFS_STATE)  ?
			{26'h000_0000, state_reg, enabled, res.range_ok,
			 trip_out, start_out} :
		(s_axi_araddr_in == UCB_OFS_PEAK)   ? {res.imax, res.imin} :
		32'h0000_0000;

	// ********************************************************************
	// Decision logic
	// ********************************************************************
	assign start_only   = ctrl_reg[UCB_CTRL_STONLY_BIT];
	assign enabled      = ctrl_reg[UCB_CTRL_OPER_BIT] & ~block_in;
	assign dly_done     = ms_cnt_reg >= dly_reg;
	assign release_cond = res_valid & (~res.range_ok | res.under_rel);

	always_comb begin
		state_next = state_reg;
		if (!enabled) begin
			state_next = UCB_ST_IDLE;
		end else begin
			unique case (state_reg)
				UCB_ST_IDLE: begin
					if (res_valid && res.range_ok && res.over_thr) begin
						state_next = UCB_ST_STARTED;
					end
				end
				UCB_ST_STARTED: begin
					if (release_cond) begin
						state_next = UCB_ST_IDLE;
					end else if (dly_done && !start_only) begin
						state_next = UCB_ST_TRIPPED;
					end
				end
				UCB_ST_TRIPPED: begin
					if (release_cond) begin
						state_next = UCB_ST_IDLE;
					end else if (start_only) begin
						state_next = UCB_ST_STARTED;
					end
				end
				default: begin
					state_next = UCB_ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_reg <= UCB_ST_IDLE;
			start_out <= 1'b0;
			trip_out  <= 1'b0;
		end else begin
			state_reg <= state_next;
			start_out <= state_next != UCB_ST_IDLE;
			trip_out  <= state_next == UCB_ST_TRIPPED;
		end
	end

	// Millisecond prescaler and delay counter, both held at zero when idle
	assign ms_tick = pre_cnt_reg == PRE_LAST;

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pre_cnt_reg <= '0;
			ms_cnt_reg  <= '0;
		end else if (state_reg == UCB_ST_IDLE) begin
			pre_cnt_reg <= '0;
			ms_cnt_reg  <= '0;
		end else begin
			pre_cnt_reg <= ms_tick ? 16'h0000 : pre_cnt_reg + 16'h0001;
			if (ms_tick && ms_cnt_reg != 16'hFFFF) begin
				ms_cnt_reg <= ms_cnt_reg + 16'h0001;
			end
		end
	end

	// ********************************************************************
	// Interrupts: sticky status, set wins over write-one-to-clear
	// ********************************************************************
	assign events[UCB_IRQ_START]   = state_next != UCB_ST_IDLE && !start_out;
	assign events[UCB_IRQ_TRIP]    = state_next == UCB_ST_TRIPPED && !trip_out;
	assign events[UCB_IRQ_RELEASE] = state_next == UCB_ST_IDLE && start_out;
	assign status_next = (status_reg &
	                      ~(wr_status ? wr_w1c_val[UCB_IRQ_W-1:0] :
	                        UCB_IRQ_RST)) | events;
	assign mask_next   = wr_mask ? wr_mask_val[UCB_IRQ_W-1:0] : mask_reg;

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			status_reg <= UCB_IRQ_RST;
			mask_reg   <= UCB_IRQ_RST;
			irq_out    <= 1'b0;
		end else begin
			status_reg <= status_next;
			mask_reg   <= mask_next;
			irq_out    <= |(status_next & mask_next);
		end
	end

	// ********************************************************************
	// Assertions
	// ********************************************************************
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);

	a_trip_needs_start: assert property (
		trip_out |-> start_out)
		else $error("trip without start");
	a_trip_after_delay: assert property (
		$rose(trip_out) |-> $past(ms_cnt_reg) >= $past(dly_reg))
		else $error("trip before delay expired");
	a_start_only_trip: assert property (
		start_only |=> !trip_out)
		else $error("trip while start-only set");
	a_disable_quiet: assert property (
		!enabled |=> !start_out && !trip_out)
		else $error("output active while disabled");
	a_start_cause: assert property (
		$rose(start_out) |-> $past(res.range_ok) && $past(res_valid))
		else $error("start outside current range");
	a_start_over_thr: assert property (
		$rose(start_out) |-> $past(res.over_thr))
		else $error("start without spread over threshold");
	a_release_hyst: assert property (
		$fell(start_out) |->
			$past(!enabled) || $past(release_cond))
		else $error("start released above reset ratio");
	a_timer_clear: assert property (
		!start_out |=> ms_cnt_reg == 16'h0000)
		else $error("delay counter not cleared");
	a_thr_bounds: assert property (
		thr_reg >= UCB_THR_MIN && thr_reg <= UCB_THR_MAX)
		else $error("threshold out of range");
	a_dly_bounds: assert property (
		dly_reg >= UCB_DLY_MIN && dly_reg <= UCB_DLY_MAX)
		else $error("delay out of range");

	c_start: cover property ($rose(start_out));
	c_trip: cover property ($rose(trip_out));
	c_release: cover property ($fell(start_out) && enabled);
	c_write: cover property (do_write ##1 s_axi_bvalid_out);

endmodule // ucb_top

// ==== testbench/ucb_src_model.sv ====
// Upstream model: one phase RMS word per sample pulse
`timescale 1ns/10ps
module ucb_src_model
	import ucb_pkg::*;
(
	input  wire logic       mclk_in,
	input  wire logic       rst_n_in,
	input  wire logic       go_in,
	input  wire ucb_phase_t val_in,
	output ucb_phase_t      phase_out,
	output logic            valid_out
);
	// Word valid one cycle; afterwards inverted, never left stale
	always_ff @(posedge mclk_in or negedge rst_n_in)
		if (!rst_n_in) {valid_out, phase_out} <= '0;
		else {valid_out, phase_out} <= {go_in, go_in ? val_in : ~phase_out};
endmodule // ucb_src_model

// ==== testbench/current_unbalance_detector_tb.sv ====
// Self-checking bench of the current unbalance detector
`timescale 1ns/10ps
module current_unbalance_detector_tb;
	import ucb_pkg::*;
	logic        mclk_in = 1'b0, rst_n_in = 1'b0;
	logic [7:0]  awa = '0, ara = '0;
	logic [31:0] wd = '0, rdt;
	logic        awv = 1'b0, wv = 1'b0, brd = 1'b1, arv = 1'b0, rrd = 1'b1;
	logic [3:0]  ws = 4'hF;
	logic        go = 1'b0, blk = 1'b0, st_exp, e, awr, wrd, bv, arr, rv;
	logic        start, trip, irq, sv;
	logic [1:0]  bre, rre;
	ucb_phase_t  ph, val = '0;
	int          err_total = 0, n_checks = 0, cyc = 0, a, b, c, k, p;
	int          tmx[8] = '{102, 103, 1536, 1535, 500, 500, 500, 500};
	int          tmn[8] = '{0, 0, 0, 0, 260, 265, 250, 245};
	ucb_top #(.MS_CYCLES(10)) ucb_top_inst (.mclk_in(mclk_in),
		.rst_n_in(rst_n_in), .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv),
		.s_axi_awready_out(awr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(ws),
		.s_axi_wvalid_in(wv), .s_axi_wready_out(wrd), .s_axi_bresp_out(bre),
		.s_axi_bvalid_out(bv), .s_axi_bready_in(brd), .s_axi_araddr_in(ara),
		.s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
		.s_axi_rdata_out(rdt), .s_axi_rresp_out(rre), .s_axi_rvalid_out(rv),
		.s_axi_rready_in(rrd), .phase_in(ph), .sample_valid_in(sv),
		.block_in(blk), .start_out(start), .trip_out(trip), .irq_out(irq));
	ucb_src_model ucb_src_model_inst (.mclk_in(mclk_in),
		.rst_n_in(rst_n_in), .go_in(go), .val_in(val), .phase_out(ph),
		.valid_out(sv));
	initial forever #50 mclk_in = ~mclk_in;
	always @(posedge mclk_in)
		if (++cyc > 20000) begin
			err_total++;
			report_and_stop();
		end
	task automatic report_and_stop();
		$display("Checks %0d, errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, x);
		n_checks++;
		if (g !== x) begin
			err_total++;
			$display("Error %0t: got %h exp %h", $time, g, x);
		end
	endtask
	task automatic chb(input logic g, x);
		chk(32'(g), 32'(x));
	endtask
	task automatic wr(input logic [7:0] ad, input logic [31:0] d,
			input logic [1:0] x = UCB_RESP_OKAY);
		awa <= ad; wd <= d;
		awv <= 1'b1; wv <= 1'b1;
		do begin
			@(posedge mclk_in);
			if (awr && awv) awv <= 1'b0;
			if (wrd && wv) wv <= 1'b0;
		end while (!bv);
		chk(32'(bre), 32'(x));
	endtask
	task automatic rd(input logic [7:0] ad, input logic [31:0] d,
			input logic [1:0] x = UCB_RESP_OKAY);
		ara <= ad; arv <= 1'b1;
		do begin
			@(posedge mclk_in);
			if (arr && arv) arv <= 1'b0;
		end while (!rv);
		chk(rdt, d);
		chk(32'(rre), 32'(x));
	endtask
	// Start follows two edges after the word is taken
	task automatic smp(input int x, y, z);
		val <= {16'(x), 16'(y), 16'(z)}; go <= 1'b1;
		@(posedge mclk_in); go <= 1'b0;
		repeat (4) @(posedge mclk_in);
	endtask
	function automatic logic exp_st(input logic s, input int a, b, c);
		int mx, mn;
		mx = a > b ? a : b; mx = mx > c ? mx : c;
		mn = a < b ? a : b; mn = mn < c ? mn : c;
		if (mx * 100 <= 10 * UCB_RATED_RST || mx * 100 >= 150 * UCB_RATED_RST)
			return 1'b0;
		return s ? (mx - mn) * 2000 >= 19 * UCB_THR_RST * mx
			: (mx - mn) * 100 > UCB_THR_RST * mx;
	endfunction
	initial begin
		void'($urandom(51));
		repeat (4) @(posedge mclk_in); rst_n_in <= 1'b1;
		@(posedge mclk_in);
		rd(UCB_OFS_CTRL, 32'h0000_0000);
		rd(UCB_OFS_THRESH, 32'h0000_0032);
		rd(UCB_OFS_DELAY, 32'h0000_03E8);
		rd(8'h40, 32'h0000_0000, UCB_RESP_SLVERR);
		wr(UCB_OFS_THRESH, 32'h0000_0005);
		rd(UCB_OFS_THRESH, 32'h0000_000A);
		wr(UCB_OFS_DELAY, 32'h0000_FFFF);
		rd(UCB_OFS_DELAY, 32'h0000_EA60);
		wr(UCB_OFS_THRESH, 32'h0000_0032);
		wr(UCB_OFS_DELAY, 32'h0000_03E8);
		wr(UCB_OFS_MASK, 32'h0000_0007);
		wr(UCB_OFS_CTRL, 32'h0000_0001);
		st_exp = 1'b0;
		// Random spreads of whole percents, then band and hysteresis edges
		for (int i = 0; i < 32; i++) begin
			k = 1 + $urandom_range(15); p = $urandom_range(70, 20);
			a = i < 24 ? 100 * k : tmx[i%8];
			c = i < 24 ? a - k * p : tmn[i%8];
			b = i < 24 ? a - k * $urandom_range(p) : a;
			e = exp_st(st_exp, a, b, c);
			if (i % 2) smp(c, b, a); else smp(a, b, c);
			chb(start, e);
			st_exp = e;
		end
		rd(UCB_OFS_STATUS, 32'h0000_0005);
		chb(irq, 1'b1);
		wr(UCB_OFS_STATUS, 32'h0000_0005);
		repeat (2) @(posedge mclk_in); chb(irq, 1'b0);
		repeat (9900) @(posedge mclk_in); chb(trip, 1'b0);
		repeat (200) @(posedge mclk_in); chb(trip, 1'b1);
		rd(UCB_OFS_STATUS, 32'h0000_0002);
		wr(UCB_OFS_CTRL, 32'h0000_0003);
		repeat (2) @(posedge mclk_in); chb(trip, 1'b0);
		chb(start, 1'b1);
		blk <= 1'b1; repeat (2) @(posedge mclk_in);
		chb(start, 1'b0);
		chb(trip, 1'b0);
		blk <= 1'b0;
		wr(UCB_OFS_CTRL, 32'h0000_0001);
		wr(UCB_OFS_DELAY, 32'h0000_0064);
		smp(500, 0, 0);
		repeat (600) @(posedge mclk_in);
		smp(500, 500, 500);
		chb(start, 1'b0);
		smp(500, 0, 0);
		repeat (600) @(posedge mclk_in); chb(trip, 1'b0);
		repeat (500) @(posedge mclk_in); chb(trip, 1'b1);
		rd(UCB_OFS_PEAK, 32'h01F4_0000);
		rd(UCB_OFS_STATE, 32'h0000_002F);
		ws <= 4'h1;
		wr(UCB_OFS_DELAY, 32'h0000_FFC8);
		ws <= 4'hF;
		rd(UCB_OFS_DELAY, 32'h0000_00C8);
		report_and_stop();
	end
endmodule // current_unbalance_detector_tb
